/* hw/sfp_fifo_dev.sv */
// FIFO device end: storage, flags, parity and depth-expansion token.
// Assumes its pin inputs come from another party and samples them through two flops.
//
// The implementer's own choices: the placing of the registers and the AHB-Lite register port.
module sfp_fifo_dev (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  sfp_if.dev               pins,
  output logic       [9:0] level,
  output logic       [1:0] parity_mode,
  output logic             write_token,
  output logic             read_token
);
  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic [sfp_pkg::SYNC_W-1:0] s1_q;
  logic [sfp_pkg::SYNC_W-1:0] s2_q;
  logic [2:0]                 prev_q;
  logic                       wclk_s, rclk_s, wen_n_s, ren_n_s, pwr_s, prd_s;
  logic                       mr_n_s, fl_s, xi_s, casc_s;
  logic [17:0]                din_s;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      s1_q   <= '0;
      s2_q   <= '0;
      prev_q <= '0;
    end
    else
    begin
      s1_q   <= {pins.write_clock, pins.read_clock, pins.write_enable_n, pins.read_enable_n,
                 pins.prog_write, pins.prog_read, pins.master_reset_n, pins.first_load_sel,
                 pins.expansion_in, pins.cascade_mode, pins.data_in};
      s2_q   <= s1_q;
      prev_q <= {s2_q[27], s2_q[26], s2_q[19]};
    end
  end

  assign {wclk_s, rclk_s, wen_n_s, ren_n_s, pwr_s, prd_s, mr_n_s, fl_s, xi_s, casc_s} =
         s2_q[27:18];
  assign din_s = s2_q[17:0];

  logic wr_rise, rd_rise, xi_rise, clr;
  assign wr_rise = wclk_s & ~prev_q[2];
  assign rd_rise = rclk_s & ~prev_q[1];
  assign xi_rise = xi_s & ~prev_q[0];
  assign clr     = ~rst_n | ~mr_n_s;

  // ------------------------------------------------------------
  // Transfer decisions
  // ------------------------------------------------------------
  logic [17:0]         prog_q;
  logic [sfp_pkg::CW-1:0] cnt_q;
  logic                empty_q, ae_q, hf_q, af_q, full_q;
  logic                wtok_q, rtok_q;
  logic                do_wr, do_rd, do_pw, do_pr;
  logic [sfp_pkg::CW-1:0] cnt_nx;
  logic [sfp_pkg::CW-1:0] p_cnt;
  logic [17:0]         wword;

  // Full or empty shown means the edge is a latent update, no transfer
  assign do_wr = wr_rise & ~wen_n_s & ~pwr_s & (~casc_s | wtok_q) & ~full_q;
  assign do_rd = rd_rise & ~ren_n_s & ~prd_s & (~casc_s | rtok_q) & ~empty_q;
  assign do_pw = wr_rise & ~wen_n_s & pwr_s;
  assign do_pr = rd_rise & ~ren_n_s & prd_s;
  // Both edges in one cycle: the write is always counted by the read update
  assign cnt_nx = cnt_q + {9'h000, do_wr} - {9'h000, do_rd};
  assign p_cnt  = {2'b00, prog_q[sfp_pkg::P_LSB +: sfp_pkg::P_W]};

  sfp_parity_unit u_par_lo (
    .din  (din_s[8:0]),
    .mode (prog_q[sfp_pkg::MODE_LSB +: 2]),
    .odd  (prog_q[sfp_pkg::ODD_BIT]),
    .dout (wword[8:0])
  );

  sfp_parity_unit u_par_hi (
    .din  (din_s[17:9]),
    .mode (prog_q[sfp_pkg::MODE_LSB +: 2]),
    .odd  (prog_q[sfp_pkg::ODD_BIT]),
    .dout (wword[17:9])
  );

  // ------------------------------------------------------------
  // Program register
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (clr)
      prog_q <= sfp_pkg::PRG_RESET;
    else if (do_pw)
      prog_q <= din_s;
  end

  // ------------------------------------------------------------
  // Storage and pointers
  // ------------------------------------------------------------
  logic [17:0]         mem [sfp_pkg::DEPTH];
  logic [sfp_pkg::AW-1:0] wptr_q, rptr_q;

  always_ff @(posedge ref_clk)
  begin
    if (do_wr)
      mem[wptr_q] <= wword;
  end

  always_ff @(posedge ref_clk)
  begin
    if (clr)
    begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q  <= '0;
    end
    else
    begin
      wptr_q <= wptr_q + {8'h00, do_wr};
      rptr_q <= rptr_q + {8'h00, do_rd};
      cnt_q  <= cnt_nx;
    end
  end

  // ------------------------------------------------------------
  // Flags: each side only moves on its own clock edge
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (clr)
    begin
      empty_q <= 1'b1;
      ae_q    <= 1'b1;
    end
    else if (rd_rise)
    begin
      empty_q <= (cnt_nx == '0);
      ae_q    <= (cnt_nx <= p_cnt);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (clr)
    begin
      full_q <= 1'b0;
      hf_q   <= 1'b0;
      af_q   <= 1'b0;
    end
    else if (wr_rise)
    begin
      full_q <= (cnt_nx == sfp_pkg::DEPTH_CNT);
      hf_q   <= (cnt_nx > sfp_pkg::HALF_CNT);
      af_q   <= (cnt_nx >= sfp_pkg::DEPTH_CNT - p_cnt);
    end
  end

  // Almost flag is not offered in depth expansion
  always_ff @(posedge ref_clk)
  begin
    if (clr)
    begin
      pins.empty_full_n       <= 1'b0;
      pins.prog_almost_flag_n <= 1'b0;
      pins.half_full_flag_n   <= 1'b1;
    end
    else
    begin
      pins.empty_full_n       <= ~(empty_q | full_q);
      pins.prog_almost_flag_n <= casc_s | ~(ae_q | af_q);
      pins.half_full_flag_n   <= ~hf_q;
    end
  end

  // ------------------------------------------------------------
  // Depth-expansion token
  // ------------------------------------------------------------
  logic       xo_set;
  logic [3:0] xo_cnt_q;
  logic       float_pend_q;
  logic       wr_pass, rd_pass;

  assign wr_pass = casc_s & do_wr & (cnt_nx == sfp_pkg::DEPTH_CNT);
  assign rd_pass = casc_s & do_rd & (cnt_nx == '0) & ~wtok_q;
  assign xo_set  = wr_pass | rd_pass;

  always_ff @(posedge ref_clk)
  begin
    if (clr)
    begin
      wtok_q <= ~fl_s;
      rtok_q <= ~fl_s;
    end
    else
    begin
      if (wr_pass)
        wtok_q <= 1'b0;
      else if (xi_rise && casc_s && !wtok_q && cnt_q == '0)
        wtok_q <= 1'b1;
      if (rd_pass)
        rtok_q <= 1'b0;
      else if (xi_rise && casc_s && !(!wtok_q && cnt_q == '0))
        rtok_q <= 1'b1;
    end
  end

  // Pulse held long enough for the next device's synchroniser
  always_ff @(posedge ref_clk)
  begin
    if (clr)
      xo_cnt_q <= '0;
    else if (xo_set)
      xo_cnt_q <= sfp_pkg::XO_CYC;
    else if (xo_cnt_q != '0)
      xo_cnt_q <= xo_cnt_q - 4'h1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (clr)
      pins.expansion_out <= 1'b0;
    else
      pins.expansion_out <= xo_set | (xo_cnt_q > 4'h1);
  end

  // ------------------------------------------------------------
  // Output bus
  // ------------------------------------------------------------
  logic drive_q;

  always_ff @(posedge ref_clk)
  begin
    if (clr)
      pins.data_out <= '0;
    else if (do_rd)
      pins.data_out <= mem[rptr_q];
    else if (do_pr && (!casc_s || !fl_s))
      pins.data_out <= prog_q;
  end

  always_ff @(posedge ref_clk)
  begin
    if (clr)
    begin
      drive_q      <= 1'b0;
      float_pend_q <= 1'b0;
    end
    else if (!casc_s)
    begin
      drive_q      <= 1'b1;
      float_pend_q <= 1'b0;
    end
    else
    begin
      if (rd_pass)
        float_pend_q <= 1'b1;
      else if (rd_rise)
        float_pend_q <= 1'b0;
      if (rd_rise && float_pend_q)
        drive_q <= 1'b0;
      else if (do_pr)
        drive_q <= ~fl_s;
      else if (do_rd)
        drive_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (clr)
      pins.data_oe_n <= 1'b1;
    else
      pins.data_oe_n <= ~drive_q;
  end

  always_ff @(posedge ref_clk)
  begin
    if (clr)
    begin
      level       <= '0;
      parity_mode <= 2'b00;
      write_token <= 1'b0;
      read_token  <= 1'b0;
    end
    else
    begin
      level       <= cnt_q;
      parity_mode <= prog_q[sfp_pkg::MODE_LSB +: 2];
      write_token <= wtok_q;
      read_token  <= rtok_q;
    end
  end
endmodule

/* hw/sfp_pkg.sv */
// Constants and types shared by the FIFO device end, its controller, the parity unit and the bench.
// Assumes one ref_clk at 10 MHz for both ends and a bench that joins the ends.
package sfp_pkg;
  localparam int          WIDTH      = 18;
  localparam int          DEPTH      = 512;
  localparam int          AW         = 9;
  localparam int          CW         = 10;
  localparam logic [9:0]  DEPTH_CNT  = 10'h200;
  localparam logic [9:0]  HALF_CNT   = 10'h100;
  localparam int          P_LSB      = 0;
  localparam int          P_W        = 8;
  localparam int          MODE_LSB   = 15;
  localparam int          ODD_BIT    = 17;
  localparam logic [17:0] PRG_RESET  = 18'h0_0010;
  localparam int          SYNC_W     = 28;
  // Pin timing: each phase of a pin sequence outlasts the two-flop synchroniser
  localparam int          CLK_NS     = 100;
  localparam int          PHASE_NS   = 400;
  localparam logic [3:0]  PHASE_CYC  = 4'((PHASE_NS + CLK_NS - 1) / CLK_NS);
  localparam int          XO_NS      = 400;
  localparam logic [3:0]  XO_CYC     = 4'((XO_NS + CLK_NS - 1) / CLK_NS);
  // Controller register map
  localparam logic [7:0]  ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_WDATA  = 8'h04;
  localparam logic [7:0]  ADDR_RDATA  = 8'h08;
  localparam logic [7:0]  ADDR_STATUS = 8'h0C;
  localparam logic [7:0]  ADDR_CFG    = 8'h10;
  localparam int          ST_BUSY    = 0;
  localparam int          ST_EF      = 1;
  localparam int          ST_PROG_ALMOST_FLAG    = 2;
  localparam int          ST_HF      = 3;
  localparam int          ST_OE      = 4;
  localparam int          CFG_CASC   = 0;
  localparam int          CFG_FL     = 1;

  typedef enum logic [1:0] {
    PAR_OFF = 2'b00,
    PAR_GEN = 2'b01,
    PAR_CHK = 2'b10,
    PAR_RSV = 2'b11
  } sfp_par_e;

  typedef enum logic [2:0] {
    CMD_NONE  = 3'b000,
    CMD_WRITE = 3'b001,
    CMD_READ  = 3'b010,
    CMD_PWR   = 3'b011,
    CMD_PRD   = 3'b100,
    CMD_MRST  = 3'b101,
    CMD_WUPD  = 3'b110,
    CMD_RUPD  = 3'b111
  } sfp_cmd_e;

  typedef enum logic [1:0] {
    HS_IDLE  = 2'b00,
    HS_SETUP = 2'b01,
    HS_HIGH  = 2'b10,
    HS_LOW   = 2'b11
  } sfp_hst_e;
endpackage

/* hw/sfp_if.sv */
// Pin bundle between one FIFO device end and its controller.
// Assumes the bench drives expansion_in from the ring and passes data_out straight through, whatever data_oe_n says.
interface sfp_if;
  logic        write_clock;
  logic        read_clock;
  logic        write_enable_n;
  logic        read_enable_n;
  logic        prog_write;
  logic        prog_read;
  logic        master_reset_n;
  logic        first_load_sel;
  logic        cascade_mode;
  logic        expansion_in;
  logic        expansion_out;
  logic [17:0] data_in;
  logic [17:0] data_out;
  logic        data_oe_n;
  logic        empty_full_n;
  logic        prog_almost_flag_n;
  logic        half_full_flag_n;

  modport dev (
    input  write_clock, read_clock, write_enable_n, read_enable_n, prog_write, prog_read,
    input  master_reset_n, first_load_sel, cascade_mode, expansion_in, data_in,
    output expansion_out, data_out, data_oe_n, empty_full_n, prog_almost_flag_n,
    output half_full_flag_n
  );

  modport host (
    output write_clock, read_clock, write_enable_n, read_enable_n, prog_write, prog_read,
    output master_reset_n, first_load_sel, cascade_mode, data_in,
    input  data_out, data_oe_n, empty_full_n, prog_almost_flag_n, half_full_flag_n
  );
endinterface

/* hw/sfp_parity_unit.sv */
// One 9-bit half of the write path: pass, generate parity or check parity.
// Assumes mode and sense come from the latched program register.
module sfp_parity_unit (
  input  wire logic [8:0] din,
  input  wire logic [1:0] mode,
  input  wire logic       odd,
  output logic      [8:0] dout
);
  logic ones8;
  logic ones9;

  always_comb
  begin
    ones8 = ^din[7:0];
    ones9 = ^din[8:0];
    dout  = din;
    case (sfp_pkg::sfp_par_e'(mode))
      sfp_pkg::PAR_GEN: dout[8] = ones8 ^ odd;
      sfp_pkg::PAR_CHK: dout[8] = (ones9 == odd);
      default:          dout[8] = din[8];
    endcase
  end
endmodule

/* hw/sfp_fifo_host.sv */
// Controller end: software orders over AHB-Lite become pin sequences toward one FIFO.
// Assumes a single AHB-Lite master and a device sampling pins through two flops.
module sfp_fifo_host (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  sfp_if.host              pins,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic      [31:0] hrdata,
  output logic             hresp
);
  // ------------------------------------------------------------
  // Bus slave: zero wait states, always OKAY
  // ------------------------------------------------------------
  logic       wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [17:0] wdata_q, rdata_q;
  logic [1:0] cfg_q;
  sfp_pkg::sfp_hst_e st_q;
  logic       take;

  assign take = hsel & hready & htrans[1];

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
    end
    else
    begin
      wr_pend_q <= take & hwrite & (hsize == 3'b010);
      wr_addr_q <= haddr[7:0];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      hrdata <= '0;
    else if (take && !hwrite)
      case (haddr[7:0])
        sfp_pkg::ADDR_WDATA:  hrdata <= {14'h0000, wdata_q};
        sfp_pkg::ADDR_RDATA:  hrdata <= {14'h0000, rdata_q};
        sfp_pkg::ADDR_STATUS: hrdata <= {27'h000_0000, pins.data_oe_n, pins.half_full_flag_n,
                                         pins.prog_almost_flag_n, pins.empty_full_n,
                                         st_q != sfp_pkg::HS_IDLE};
        sfp_pkg::ADDR_CFG:    hrdata <= {30'h0000_0000, cfg_q};
        default:              hrdata <= '0;
      endcase
  end

  always_ff @(posedge ref_clk)
  begin
    hreadyout <= 1'b1;
    hresp     <= 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      wdata_q <= '0;
      cfg_q   <= '0;
    end
    else if (wr_pend_q)
    begin
      if (wr_addr_q == sfp_pkg::ADDR_WDATA)
        wdata_q <= hwdata[17:0];
      if (wr_addr_q == sfp_pkg::ADDR_CFG)
        cfg_q <= hwdata[1:0];
    end
  end

  // ------------------------------------------------------------
  // Pin sequencer: setup, clock high, clock low
  // ------------------------------------------------------------
  sfp_pkg::sfp_cmd_e cmd_q;
  logic [3:0]        ph_q;
  logic              start;

  // Orders arriving while busy are dropped; software polls the busy bit first
  assign start = wr_pend_q & (wr_addr_q == sfp_pkg::ADDR_CTRL) & (st_q == sfp_pkg::HS_IDLE)
               & (hwdata[2:0] != 3'b000);

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      st_q  <= sfp_pkg::HS_IDLE;
      cmd_q <= sfp_pkg::CMD_NONE;
      ph_q  <= '0;
    end
    else
    begin
      if (start)
        cmd_q <= sfp_pkg::sfp_cmd_e'(hwdata[2:0]);
      if (start || ph_q == 4'h1)
        ph_q <= sfp_pkg::PHASE_CYC;
      else if (ph_q != '0)
        ph_q <= ph_q - 4'h1;
      case (st_q)
        sfp_pkg::HS_IDLE:  if (start) st_q <= sfp_pkg::HS_SETUP;
        sfp_pkg::HS_SETUP: if (ph_q == 4'h1) st_q <= sfp_pkg::HS_HIGH;
        sfp_pkg::HS_HIGH:  if (ph_q == 4'h1) st_q <= sfp_pkg::HS_LOW;
        sfp_pkg::HS_LOW:   if (ph_q == 4'h1) st_q <= sfp_pkg::HS_IDLE;
        default:           st_q <= sfp_pkg::HS_IDLE;
      endcase
    end
  end

  logic act, hi, is_w, is_r;
  assign act  = st_q != sfp_pkg::HS_IDLE;
  assign hi   = st_q == sfp_pkg::HS_HIGH;
  assign is_w = cmd_q inside {sfp_pkg::CMD_WRITE, sfp_pkg::CMD_PWR, sfp_pkg::CMD_WUPD};
  assign is_r = cmd_q inside {sfp_pkg::CMD_READ, sfp_pkg::CMD_PRD, sfp_pkg::CMD_RUPD};

  // Enables are set a phase before the clock edge and released after it
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      pins.write_clock    <= 1'b0;
      pins.read_clock     <= 1'b0;
      pins.write_enable_n <= 1'b1;
      pins.read_enable_n  <= 1'b1;
      pins.prog_write     <= 1'b0;
      pins.prog_read      <= 1'b0;
      pins.master_reset_n <= 1'b1;
      pins.data_in        <= '0;
      pins.first_load_sel <= 1'b0;
      pins.cascade_mode   <= 1'b0;
    end
    else
    begin
      pins.write_clock    <= hi & is_w;
      pins.read_clock     <= hi & is_r;
      pins.write_enable_n <= ~(act & (cmd_q == sfp_pkg::CMD_WRITE || cmd_q == sfp_pkg::CMD_PWR));
      pins.read_enable_n  <= ~(act & (cmd_q == sfp_pkg::CMD_READ || cmd_q == sfp_pkg::CMD_PRD));
      pins.prog_write     <= act & (cmd_q == sfp_pkg::CMD_PWR);
      pins.prog_read      <= act & (cmd_q == sfp_pkg::CMD_PRD);
      pins.master_reset_n <= ~(hi & (cmd_q == sfp_pkg::CMD_MRST));
      pins.data_in        <= wdata_q;
      pins.first_load_sel <= cfg_q[sfp_pkg::CFG_FL];
      pins.cascade_mode   <= cfg_q[sfp_pkg::CFG_CASC];
    end
  end

  // Read data captured at the end of the low phase, long after the device answers
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      rdata_q <= '0;
    else if (st_q == sfp_pkg::HS_LOW && ph_q == 4'h1 && is_r)
      rdata_q <= pins.data_out;
  end
endmodule

/* verification/sfp_fifo_sva.sv */
// Pin checker for the controller and FIFO end joined by one bundle.
// Assumes the bench instantiates it beside that bundle, one clock domain.
module sfp_fifo_sva (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        write_clock,
  input wire logic        read_clock,
  input wire logic        write_enable_n,
  input wire logic [17:0] data_in,
  input wire logic [17:0] data_out,
  input wire logic        data_oe_n,
  input wire logic        cascade_mode,
  input wire logic        expansion_out,
  input wire logic        empty_full_n,
  input wire logic        half_full_flag_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  AST_WCLK_PULSE: assert property ($rose(write_clock) |-> write_clock[*4] ##1 !write_clock)
    else $error("write clock pulse length wrong");
  AST_RCLK_PULSE: assert property ($rose(read_clock) |-> read_clock[*4] ##1 !read_clock)
    else $error("read clock pulse length wrong");
  AST_WEN_HELD: assert property ($rose(write_clock) |-> $stable(write_enable_n)[*4])
    else $error("write enable moved during clock");
  AST_DIN_HELD: assert property ($rose(write_clock) |-> $stable(data_in)[*4])
    else $error("write data moved during clock");
  // Flags may move only a few edges behind their own pin clock
  AST_HF_WCLK: assert property ($changed(half_full_flag_n) |-> $past(write_clock, 2))
    else $error("half flag moved without write clock");
  AST_EF_CLK: assert property ($changed(empty_full_n) |->
    $past(read_clock, 2) || $past(write_clock, 2))
    else $error("boundary flag moved without clock");
  AST_DOUT_RCLK: assert property ($changed(data_out) |-> $past(read_clock, 2))
    else $error("data out moved without read clock");
  AST_OE_SOLO: assert property ($past(rst_n, 4) && !cascade_mode |-> !data_oe_n)
    else $error("standalone outputs floated");
  AST_XO_SOLO: assert property (!cascade_mode |-> !expansion_out)
    else $error("token passed while standalone");

  cover property ($rose(write_clock) && !write_enable_n);
  cover property ($rose(empty_full_n));
  cover property ($fell(half_full_flag_n));
endmodule

/* verification/sfp_fifo_bench.sv */
// Bench: AHB-Lite master on the controller, FIFO end on the pin bundle.
// Assumes standalone use; the expansion ring is closed on the one device.
module sfp_fifo_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk = 1'h0;
  logic        rst_n = 1'h0;
  logic        hsel = 1'h0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic [9:0]  level;
  int          err_count = 0;
  int          cmp_count = 0;

  always #50 ref_clk = ~ref_clk;

  sfp_if sfp_if_i ();
  assign sfp_if_i.expansion_in = sfp_if_i.expansion_out;

  sfp_fifo_host sfp_fifo_host_i (.ref_clk(ref_clk), .rst_n(rst_n), .pins(sfp_if_i.host),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp));
  sfp_fifo_dev sfp_fifo_dev_i (.ref_clk(ref_clk), .rst_n(rst_n), .pins(sfp_if_i.dev),
    .level(level), .parity_mode(), .write_token(), .read_token());
  sfp_fifo_sva sfp_fifo_sva_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .write_clock(sfp_if_i.write_clock), .read_clock(sfp_if_i.read_clock),
    .write_enable_n(sfp_if_i.write_enable_n), .data_in(sfp_if_i.data_in),
    .data_out(sfp_if_i.data_out), .data_oe_n(sfp_if_i.data_oe_n),
    .cascade_mode(sfp_if_i.cascade_mode), .expansion_out(sfp_if_i.expansion_out),
    .empty_full_n(sfp_if_i.empty_full_n), .half_full_flag_n(sfp_if_i.half_full_flag_n));

  // ----------------
  // Shared tasks
  // ----------------
  task automatic end_of_test;
    if (err_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    @(posedge ref_clk);
    while (hreadyout !== 1'h1)
      @(posedge ref_clk);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge ref_clk);
    while (hreadyout !== 1'h1)
      @(posedge ref_clk);
    r = hrdata;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'h0, a, 32'h0000_0000, r);
    chk(r, e);
  endtask

  // Busy rises on the edge that ends the order's data phase; polling still starts one cycle after that
  task automatic cmd(input sfp_pkg::sfp_cmd_e c, input logic [17:0] d);
    logic [31:0] r;
    ahb(1'h1, sfp_pkg::ADDR_WDATA, {14'h0000, d}, r);
    ahb(1'h1, sfp_pkg::ADDR_CTRL, {29'h0000_0000, c}, r);
    @(posedge ref_clk);
    r = 32'h0000_0001;
    while (r[0] !== 1'h0)
      ahb(1'h0, sfp_pkg::ADDR_STATUS, 32'h0000_0000, r);
  endtask

  // ----------------
  // Scenarios
  // ----------------
  task automatic t_reset;
    logic [31:0] r;
    ahb(1'h1, 8'h20, 32'hFFFF_FFFF, r);
    rdc(8'h20, 32'h0000_0000);
    ahb(1'h1, sfp_pkg::ADDR_CFG, 32'h0000_0000, r);
    rdc(sfp_pkg::ADDR_CFG, 32'h0000_0000);
    rdc(sfp_pkg::ADDR_STATUS, 32'h0000_0008);
  endtask

  task automatic t_par(input logic [1:0] m, input logic o, input logic [17:0] d,
                       input logic pg);
    logic [17:0] e;
    e = d;
    if (m == 2'h1)
    begin
      e[8] = ^d[7:0] ^ o;
      e[17] = ^d[16:9] ^ o;
    end
    if (m == 2'h2)
    begin
      e[8] = ~(^d[8:0] ^ o);
      e[17] = ~(^d[17:9] ^ o);
    end
    if (pg)
      cmd(sfp_pkg::CMD_PWR, {o, m, 7'h00, 8'h10});
    cmd(sfp_pkg::CMD_WRITE, d);
    rdc(sfp_pkg::ADDR_STATUS, 32'h0000_0008);
    cmd(sfp_pkg::CMD_RUPD, 18'h0_0000);
    rdc(sfp_pkg::ADDR_STATUS, 32'h0000_000A);
    cmd(sfp_pkg::CMD_READ, 18'h0_0000);
    rdc(sfp_pkg::ADDR_RDATA, {14'h0000, e});
    rdc(sfp_pkg::ADDR_STATUS, 32'h0000_0008);
  endtask

  // Crossing half full from the read side must wait for a write edge
  task automatic t_fill;
    for (int i = 0; i < 257; i++)
      cmd(sfp_pkg::CMD_WRITE, 18'(i));
    cmd(sfp_pkg::CMD_RUPD, 18'h0_0000);
    rdc(sfp_pkg::ADDR_STATUS, 32'h0000_0006);
    cmd(sfp_pkg::CMD_READ, 18'h0_0000);
    rdc(sfp_pkg::ADDR_RDATA, 32'h0000_0000);
    rdc(sfp_pkg::ADDR_STATUS, 32'h0000_0006);
    cmd(sfp_pkg::CMD_WUPD, 18'h3_FFFF);
    rdc(sfp_pkg::ADDR_STATUS, 32'h0000_000E);
    chk({22'h00_0000, level}, 32'h0000_0100);
    cmd(sfp_pkg::CMD_WRITE, 18'h0_0101);
    rdc(sfp_pkg::ADDR_STATUS, 32'h0000_0006);
    for (int i = 1; i < 258; i++)
    begin
      cmd(sfp_pkg::CMD_READ, 18'h0_0000);
      rdc(sfp_pkg::ADDR_RDATA, 32'(i));
    end
    cmd(sfp_pkg::CMD_WUPD, 18'h0_0000);
    cmd(sfp_pkg::CMD_RUPD, 18'h0_0000);
    rdc(sfp_pkg::ADDR_STATUS, 32'h0000_0008);
  endtask

  // Program read returns the last programmed word and leaves the flags alone
  task automatic t_prog;
    cmd(sfp_pkg::CMD_PRD, 18'h0_0000);
    rdc(sfp_pkg::ADDR_RDATA, 32'h0002_0010);
    rdc(sfp_pkg::ADDR_STATUS, 32'h0000_0008);
  endtask

  // ----------------
  // Run
  // ----------------
  initial
  begin
    #5_000_000;
    err_count++;
    end_of_test;
  end

  initial
  begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'h1;
    @(posedge ref_clk);
    t_reset;
    t_par(2'h0, 1'h0, 18'h3_A5C3, 1'h0);
    t_par(2'h1, 1'h1, 18'h2_0E03, 1'h1);
    t_par(2'h1, 1'h0, 18'h1_FE01, 1'h1);
    t_par(2'h2, 1'h1, 18'h0_0007, 1'h1);
    t_par(2'h2, 1'h0, 18'h2_0E03, 1'h1);
    t_par(2'h3, 1'h0, 18'h2_5A5A, 1'h1);
    t_par(2'h0, 1'h1, 18'h1_C3A5, 1'h1);
    t_fill;
    t_prog;
    end_of_test;
  end
endmodule
